// [common/saeic_pkg.sv]
package saeic_pkg;

  // Register byte offsets on the APB.
  localparam logic [7:0] OFS_CORE_CTRL = 8'h00;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h04;
  localparam logic [7:0] OFS_STATUS_WORD = 8'h08;
  localparam logic [7:0] OFS_COMP_CTRL = 8'h0c;
  localparam logic [7:0] OFS_ASYNC_STAT = 8'h10;
  localparam logic [7:0] OFS_SLEEP_STAT = 8'h14;

  // Field positions in core_control_reg.
  localparam int POS_SLEEP_EN = 6;
  localparam int POS_KIND_HI = 5;
  localparam int POS_KIND_LO = 4;
  localparam int POS_EXT_IRQ_PIN_ONE_SENSE = 2;
  localparam int POS_EXT_IRQ_PIN_ZERO_SENSE = 0;
  // Field positions in the other registers.
  localparam int POS_MASK_ONE = 7;
  localparam int POS_MASK_ZERO = 6;
  localparam int POS_GLOBAL_EN = 7;
  localparam int POS_COMP_OFF = 7;
  localparam int POS_ASYNC_SEL = 3;

  // Values after reset.
  localparam logic [7:0] RST_CORE_CTRL = 8'h00;
  localparam logic [1:0] RST_MASK = 2'h0;

  // Sense select encodings for both pins.
  localparam logic [1:0] SENSE_LOW = 2'h0;
  localparam logic [1:0] SENSE_RSVD = 2'h1;
  localparam logic [1:0] SENSE_FALL = 2'h2;
  localparam logic [1:0] SENSE_RISE = 2'h3;

  // Sleep kind encodings.
  localparam logic [1:0] KIND_IDLE = 2'h0;
  localparam logic [1:0] KIND_RSVD = 2'h1;
  localparam logic [1:0] KIND_PDOWN = 2'h2;
  localparam logic [1:0] KIND_PSAVE = 2'h3;

  // Reset delay timeout and its count of cycles at 125 MHz.
  localparam int CLK_PERIOD_NS = 8;
  localparam int TOUT_NS = 16000;
  localparam int TOUT_CYC = (TOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] TOUT_LIM = CNT_W'(TOUT_CYC);
  localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;

  // Sleep states of the sequencer.
  typedef enum logic [1:0] {
    ST_AWAKE = 2'b00,
    ST_IDLE = 2'b01,
    ST_PDOWN = 2'b10,
    ST_PSAVE = 2'b11
  } saeic_sleep_e;

  // True when the sense select asks for low level sensing.
  function automatic logic saeic_is_level(input logic [1:0] s);
    return s == SENSE_LOW;
  endfunction

  // True when the sense select asks for either edge.
  function automatic logic saeic_is_edge(input logic [1:0] s);
    return s == SENSE_FALL || s == SENSE_RISE;
  endfunction

endpackage

// [core/saeic_pin_sense.sv]
`timescale 1ns/1ps
`default_nettype none
module saeic_pin_sense (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_pin,
  input wire logic [1:0] i_sense,
  input wire logic i_freeze,
  input wire logic i_ack,
  output logic o_req,
  output logic o_long_low
);
  import saeic_pkg::*;

  // All state of the pin sensing unit.
  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
    logic flag;
    logic [CNT_W-1:0] cnt;
    logic long_low;
  } saeic_pin_s;

  saeic_pin_s q;
  saeic_pin_s d;
  logic edge_hit;

  // Edges are seen on the second stage only, never on the first.
  always_comb begin
    d = q;
    d.s1 = i_pin;
    d.s2 = q.s1;
    d.prev = q.s2;
    edge_hit = 1'b0;
    // The pin is sensed even when the port drives it, so a write can
    // raise a software interrupt.
    if (i_sense == SENSE_FALL) begin
      edge_hit = q.prev && !q.s2;
    end else if (i_sense == SENSE_RISE) begin
      edge_hit = !q.prev && q.s2;
    end
    // The edge flag lives only in edge modes; reserved code drops it.
    if (!saeic_is_edge(i_sense)) begin
      d.flag = 1'b0;
    end else if (edge_hit && !i_freeze) begin
      // A new edge wins over an acknowledge in the same cycle.
      d.flag = 1'b1;
    end else if (i_ack) begin
      d.flag = 1'b0;
    end
    // Measure how long the pin has stayed low, saturating past the
    // reset delay so a short pulse never counts as long.
    if (q.s2) begin
      d.cnt = CNT_ZERO;
    end else if (q.cnt <= TOUT_LIM) begin
      d.cnt = q.cnt + 12'h001;
    end
    d.long_low = !q.s2 && (q.cnt > TOUT_LIM);
  end

  // Register the whole unit.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      // Synchroniser and edge history start at the pulled-up idle level,
      // so leaving reset never looks like an edge or a low level.
      q <= '0;
      q.s1 <= 1'b1;
      q.s2 <= 1'b1;
      q.prev <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // A low level keeps asking for as long as the pin stays low.
  assign o_req = (saeic_is_level(i_sense) && !q.s2) || q.flag;
  assign o_long_low = q.long_low;

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  level_holds_a:
    assert property (saeic_is_level(i_sense) && !q.s1 ##1
                     saeic_is_level(i_sense) |-> o_req)
    else $error("Level request dropped while pin low.");

  rsvd_quiet_a:
    assert property (i_sense == SENSE_RSVD && $past(i_sense) == SENSE_RSVD
                     |-> !o_req)
    else $error("Request raised with reserved sense code.");

  short_low_a:
    assert property ($fell(q.s2) |-> !o_long_low ##1 !o_long_low [*8])
    else $error("Long low reported too early.");

endmodule
`default_nettype wire

// [core/saeic_core.sv]
// Operation
// - Pin one interrupt needs global and mask enable.
// - Pin one sense: low, falling, rising.
// - Pin zero gated alike, same sense codes.
// - Sleep needs enable bit and sleep instruction.
// - Enabled interrupt wakes, handler, then resume.
// - Reset during sleep restarts at reset vector.
// - Registers and memories kept across sleep.
// - Deep wake by level needs long low.
// - Idle halts only CPU; all interrupts wake.
// - Comparator off bit removes comparator wakeup.
// - Idle wake resumes at once.
// - Kind 10 enters power down, oscillator stops.
// - Enabled watchdog timeout wakes from power down.
// - Without watchdog only reset or level wakes.
// - Kind 11 is power down plus timer two.
// - Async timer two runs and wakes power save.
// - Pin driven as output still triggers.
// - Level mode requests while pin stays low.
`timescale 1ns/1ps
`default_nettype none
module saeic_core (
  input wire logic i_core_clk,
  input wire logic i_rst,
  // APB slave port.
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // External pins, asynchronous to the core clock.
  input wire logic i_ext_irq_pin_zero,
  input wire logic i_ext_irq_pin_one,
  input wire logic i_ext_reset_pin,
  // Core side, on the core clock.
  input wire logic i_sleep_instr,
  input wire logic i_irq_ack_zero,
  input wire logic i_irq_ack_one,
  input wire logic i_wdt_enable,
  input wire logic i_wdt_timeout,
  input wire logic i_timer2_irq,
  input wire logic i_comparator_irq,
  input wire logic i_other_irq,
  output logic o_ext_irq_zero_req,
  output logic o_ext_irq_one_req,
  output logic o_cpu_halt,
  output logic o_main_osc_stop,
  output logic o_timer2_run,
  output logic o_comparator_pwr_dn,
  output logic o_wake_resume,
  output logic o_wake_reset
);
  import saeic_pkg::*;

  // All state of the sequencer and its registers.
  typedef struct packed {
    saeic_sleep_e st;
    logic [7:0] ctrl;
    logic [1:0] mask;
    logic gie;
    logic comp_off;
    logic async_sel;
    logic [31:0] rdata;
    logic req0;
    logic req1;
    logic wake_irq;
    logic wake_rst;
    logic rst_s1;
    logic rst_s2;
  } saeic_core_s;

  saeic_core_s q;
  saeic_core_s d;

  // Decoded fields of the control register.
  logic [1:0] sense0;
  logic [1:0] sense1;
  logic [1:0] kind;
  logic sleep_en;
  // Raw requests from the two sensing units.
  logic raw0;
  logic raw1;
  logic long0;
  logic long1;
  // Qualified wake sources.
  logic en0;
  logic en1;
  logic idle_wake;
  logic lvl_wake;
  logic pd_wake;
  logic ps_wake;
  logic deep;
  logic sleep_go;
  // Bus decode.
  logic wr_go;
  logic rd_setup;
  logic hit;

  assign sense0 = q.ctrl[POS_EXT_IRQ_PIN_ZERO_SENSE +: 2];
  assign sense1 = q.ctrl[POS_EXT_IRQ_PIN_ONE_SENSE +: 2];
  assign kind = {q.ctrl[POS_KIND_HI], q.ctrl[POS_KIND_LO]};
  assign sleep_en = q.ctrl[POS_SLEEP_EN];
  assign deep = (q.st == ST_PDOWN) || (q.st == ST_PSAVE);

  // Pin zero sensing; edges are not latched while the clock would be off.
  saeic_pin_sense u_pin_zero (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_pin(i_ext_irq_pin_zero),
    .i_sense(sense0),
    .i_freeze(deep),
    .i_ack(i_irq_ack_zero),
    .o_req(raw0),
    .o_long_low(long0)
  );

  // Pin one sensing, identical to pin zero.
  saeic_pin_sense u_pin_one (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_pin(i_ext_irq_pin_one),
    .i_sense(sense1),
    .i_freeze(deep),
    .i_ack(i_irq_ack_one),
    .o_req(raw1),
    .o_long_low(long1)
  );

  // Wake source qualification.
  always_comb begin
    en0 = q.gie && q.mask[0];
    en1 = q.gie && q.mask[1];
    // Idle keeps every source alive, the comparator unless powered
    // off by software.
    idle_wake = (en0 && raw0) || (en1 && raw1) || i_wdt_timeout ||
                (q.gie && (i_timer2_irq || i_other_irq ||
                 (i_comparator_irq && !q.comp_off)));
    // Deep sleep wakes on a level only after the reset delay.
    lvl_wake = (en0 && saeic_is_level(sense0) && long0) ||
               (en1 && saeic_is_level(sense1) && long1);
    // Edges are ignored here on purpose: the clock that would see
    // them is stopped.
    pd_wake = lvl_wake || (i_wdt_enable && i_wdt_timeout);
    // Power save adds the asynchronous timer two.
    ps_wake = pd_wake || (q.async_sel && q.gie && i_timer2_irq);
    // The reserved sleep kind is treated as no sleep at all.
    sleep_go = i_sleep_instr && sleep_en && kind != KIND_RSVD;
  end

  // APB decode; the slave never inserts wait states.
  always_comb begin
    wr_go = i_psel && i_penable && i_pwrite;
    rd_setup = i_psel && !i_penable && !i_pwrite;
    hit = i_paddr == OFS_CORE_CTRL || i_paddr == OFS_IRQ_MASK ||
          i_paddr == OFS_STATUS_WORD || i_paddr == OFS_COMP_CTRL ||
          i_paddr == OFS_ASYNC_STAT || i_paddr == OFS_SLEEP_STAT;
  end

  // Next state of everything.
  always_comb begin
    d = q;
    d.wake_irq = 1'b0;
    d.wake_rst = 1'b0;
    // Reset pin synchroniser, second stage feeds the logic.
    d.rst_s1 = i_ext_reset_pin;
    d.rst_s2 = q.rst_s1;
    // Register writes; sleep itself never touches them.
    if (wr_go) begin
      case (i_paddr)
        OFS_CORE_CTRL: begin
          // Bit 7 is reserved and reads zero.
          d.ctrl = {1'b0, i_pwdata[6:0]};
        end
        OFS_IRQ_MASK: begin
          d.mask = {i_pwdata[POS_MASK_ONE], i_pwdata[POS_MASK_ZERO]};
        end
        OFS_STATUS_WORD: begin
          d.gie = i_pwdata[POS_GLOBAL_EN];
        end
        OFS_COMP_CTRL: begin
          d.comp_off = i_pwdata[POS_COMP_OFF];
        end
        OFS_ASYNC_STAT: begin
          d.async_sel = i_pwdata[POS_ASYNC_SEL];
        end
        default: begin
          // The sleep status and unmapped words ignore writes.
        end
      endcase
    end
    // Read data is captured in the setup phase.
    if (rd_setup) begin
      d.rdata = 32'h0000_0000;
      case (i_paddr)
        OFS_CORE_CTRL: d.rdata[7:0] = q.ctrl;
        OFS_IRQ_MASK: begin
          d.rdata[POS_MASK_ONE] = q.mask[1];
          d.rdata[POS_MASK_ZERO] = q.mask[0];
        end
        OFS_STATUS_WORD: d.rdata[POS_GLOBAL_EN] = q.gie;
        OFS_COMP_CTRL: d.rdata[POS_COMP_OFF] = q.comp_off;
        OFS_ASYNC_STAT: d.rdata[POS_ASYNC_SEL] = q.async_sel;
        OFS_SLEEP_STAT: d.rdata[3:0] = {q.req1, q.req0, q.st};
        default: d.rdata = 32'h0000_0000;
      endcase
    end
    // Requests to the core, gated by both enables.
    // The sense code picks level or edge inside each unit.
    d.req0 = en0 && raw0;
    d.req1 = en1 && raw1;
    // Sleep sequencing.
    case (q.st)
      ST_AWAKE: begin
        if (sleep_go) begin
          case (kind)
            KIND_IDLE: d.st = ST_IDLE;
            KIND_PDOWN: d.st = ST_PDOWN;
            default: d.st = ST_PSAVE;
          endcase
        end
      end
      ST_IDLE: begin
        if (q.rst_s2) begin
          d.st = ST_AWAKE;
          d.wake_rst = 1'b1;
        end else if (idle_wake) begin
          // No start-up delay out of idle.
          d.st = ST_AWAKE;
          d.wake_irq = 1'b1;
        end
      end
      ST_PDOWN: begin
        if (q.rst_s2) begin
          d.st = ST_AWAKE;
          d.wake_rst = 1'b1;
        end else if (pd_wake) begin
          d.st = ST_AWAKE;
          d.wake_irq = 1'b1;
        end
      end
      ST_PSAVE: begin
        if (q.rst_s2) begin
          d.st = ST_AWAKE;
          d.wake_rst = 1'b1;
        end else if (ps_wake) begin
          d.st = ST_AWAKE;
          d.wake_irq = 1'b1;
        end
      end
      default: d.st = ST_AWAKE;
    endcase
  end

  // Register the whole block.
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      q <= '0;
      q.st <= ST_AWAKE;
      q.ctrl <= RST_CORE_CTRL;
      q.mask <= RST_MASK;
    end else begin
      q <= d;
    end
  end

  // Outputs; read data, requests and wake pulses come straight from flip-flops.
  assign o_prdata = q.rdata;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !hit;
  assign o_ext_irq_zero_req = q.req0;
  assign o_ext_irq_one_req = q.req1;
  assign o_cpu_halt = q.st != ST_AWAKE;
  // The main oscillator stops only in the two deep modes.
  assign o_main_osc_stop = deep;
  // Timer two keeps counting in power save when clocked apart.
  assign o_timer2_run = !deep || (q.st == ST_PSAVE && q.async_sel);
  assign o_comparator_pwr_dn = q.comp_off;
  assign o_wake_resume = q.wake_irq;
  assign o_wake_reset = q.wake_rst;

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  // Sleep entry takes one edge from the instruction.
  sequence enter_s;
    q.st == ST_AWAKE && sleep_go;
  endsequence

  sequence halted_s;
    o_cpu_halt && !o_wake_resume && !o_wake_reset;
  endsequence

  ext_irq_pin_one_gate_a:
    assert property (o_ext_irq_one_req |-> $past(q.gie && q.mask[1]))
    else $error("Pin one request without both enables.");

  ext_irq_pin_zero_gate_a:
    assert property (o_ext_irq_zero_req |-> $past(q.gie && q.mask[0]))
    else $error("Pin zero request without both enables.");

  sleep_enter_a:
    assert property (enter_s |=> halted_s)
    else $error("Sleep not entered after instruction.");

  sleep_cause_a:
    assert property ($rose(o_cpu_halt) |->
                     $past(i_sleep_instr && sleep_en))
    else $error("Halt without enabled sleep instruction.");

  idle_fast_a:
    assert property (q.st == ST_IDLE && idle_wake && !q.rst_s2
                     |=> !o_cpu_halt && o_wake_resume)
    else $error("Idle wake was delayed.");

  reset_wake_a:
    assert property (o_cpu_halt && q.rst_s2
                     |=> o_wake_reset && !o_wake_resume && !o_cpu_halt)
    else $error("Reset during sleep did not restart.");

  osc_stop_a:
    assert property (enter_s ##0 kind == KIND_PDOWN
                     |=> o_main_osc_stop [*1] ##0 q.st == ST_PDOWN)
    else $error("Power down did not stop the oscillator.");

  pd_edge_a:
    assert property (q.st == ST_PDOWN && !i_wdt_enable && !q.rst_s2 &&
                     !lvl_wake |=> q.st == ST_PDOWN)
    else $error("Power down woke without reset or level.");

  wdt_wake_a:
    assert property (q.st == ST_PDOWN && i_wdt_enable && i_wdt_timeout
                     |=> !o_cpu_halt)
    else $error("Watchdog did not wake power down.");

  ps_timer_a:
    assert property (q.st == ST_PSAVE && q.async_sel && q.gie &&
                     i_timer2_irq && !q.rst_s2 |=> o_wake_resume)
    else $error("Timer two did not wake power save.");

  regs_kept_a:
    assert property (o_cpu_halt && !wr_go |=> $stable(q.ctrl) &&
                     $stable(q.mask) && $stable(q.gie))
    else $error("Register changed by sleep.");

endmodule
`default_nettype wire

// [tb/saeic_ext_src.sv]
`timescale 1ns/1ps
`default_nettype none
// Outside circuits: two pulled-up interrupt pins and the reset pin.
module saeic_ext_src (
  input wire logic i_clk,
  output logic o_pin_zero,
  output logic o_pin_one,
  output logic o_reset_pin
);
  // Pins rest at the pulled-up level and reset rests inactive.
  initial begin
    o_pin_zero = 1'b1;
    o_pin_one = 1'b1;
    o_reset_pin = 1'b0;
  end
  // Moves one pin just after a rising edge.
  task automatic drive(input int idx, input logic v);
    @(posedge i_clk);
    if (idx == 0) begin
      o_pin_zero <= v;
    end else begin
      o_pin_one <= v;
    end
  endtask
  // Holds a pin low for a set span; long spans wake deep sleep.
  task automatic low_for(input int idx, input int n);
    drive(idx, 1'b0);
    repeat (n) @(posedge i_clk);
    drive(idx, 1'b1);
  endtask
  // Raises the reset pin for n cycles.
  task automatic reset_pulse(input int n);
    @(posedge i_clk);
    o_reset_pin <= 1'b1;
    repeat (n) @(posedge i_clk);
    o_reset_pin <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench: APB driver, pin model and a result monitor.
module tb;
  import saeic_pkg::*;
  logic clk, rst, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic pready, pslverr, last_err, pin0, pin1, rpin;
  logic slp, ack0, ack1, wdt_en, wdt_to, t2, cmp, oth;
  logic req0, req1, halt, osc, t2run, cmpdn, wres, wrst;
  int n_errors = 0, total_checks = 0, cyc = 0;
  // Expected results, oldest first.
  logic [31:0] exp_q[$];
  logic [7:0] ra[5] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h0c};
  logic [31:0] rm[5] = '{32'h7f, 32'hc0, 32'h80, 32'h08, 32'h80};
  saeic_core dut (
    .i_core_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_ext_irq_pin_zero(pin0), .i_ext_irq_pin_one(pin1),
    .i_ext_reset_pin(rpin), .i_sleep_instr(slp),
    .i_irq_ack_zero(ack0), .i_irq_ack_one(ack1),
    .i_wdt_enable(wdt_en), .i_wdt_timeout(wdt_to), .i_timer2_irq(t2),
    .i_comparator_irq(cmp), .i_other_irq(oth),
    .o_ext_irq_zero_req(req0), .o_ext_irq_one_req(req1),
    .o_cpu_halt(halt), .o_main_osc_stop(osc), .o_timer2_run(t2run),
    .o_comparator_pwr_dn(cmpdn), .o_wake_resume(wres), .o_wake_reset(wrst)
  );
  saeic_ext_src src (.i_clk(clk), .o_pin_zero(pin0), .o_pin_one(pin1),
    .o_reset_pin(rpin));
  always #4 clk = ~clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // A hang ends the run as a mismatch; the tests need under 6000 cycles.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      wrap_up();
    end
  end
  task automatic take(input logic [31:0] seen);
    if (exp_q.size() == 0) begin
      n_errors++;
      $display("ERROR t=%0t unexpected result %h", $time, seen);
    end else begin
      check(seen, exp_q.pop_front());
    end
  endtask
  // Compares each completed read and each wake pulse with the oldest note.
  always @(posedge clk) begin
    if (!rst && psel && penable && !pwrite && pready === 1'b1) begin
      take(prdata);
    end
    if (wres === 1'b1 || wrst === 1'b1) begin
      take({30'h0, wrst, wres});
    end
  end
  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic ack(input int p);
    if (p == 1) begin
      ack1 <= 1'b1;
    end else begin
      ack0 <= 1'b1;
    end
    @(posedge clk);
    ack0 <= 1'b0;
    ack1 <= 1'b0;
  endtask
  // Sleep instruction, then halt, oscillator stop and timer run compared.
  task automatic sleep_now(input logic [2:0] e);
    slp <= 1'b1;
    @(posedge clk);
    slp <= 1'b0;
    @(negedge clk);
    check(32'({halt, osc, t2run}), 32'(e));
    @(posedge clk);
  endtask
  task automatic asleep(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
    check(32'(halt), 32'h1);
    @(posedge clk);
  endtask
  // Counts cycles to wake; extra edges let the monitor take the pulse.
  task automatic wait_wake(input int lo, input int hi);
    int k;
    k = 0;
    while (k < hi) begin
      @(negedge clk);
      if (halt === 1'b0) begin
        break;
      end
      k++;
    end
    check(32'(k >= lo && k < hi), 32'h1);
    repeat (3) @(posedge clk);
  endtask
  // Drives a pin low then high and reads the request bits after each.
  task automatic sense_run(input int p, input logic [1:0] c, input logic m,
      input logic e);
    logic [31:0] b, x;
    b = (p == 1) ? 32'h8 : 32'h4;
    wr(8'h04, 32'h0);
    wr(8'h00, {28'h0, c, c});
    wr(8'h04, {24'h0, m, m, 6'h0});
    src.drive(p, 1'b0);
    repeat (8) @(posedge clk);
    x = (e && c inside {SENSE_LOW, SENSE_FALL}) ? b : 32'h0;
    rd(8'h14, x);
    check(32'({req1, req0, 2'b00}), x);
    src.drive(p, 1'b1);
    repeat (8) @(posedge clk);
    x = (e && c[1]) ? b : 32'h0;
    rd(8'h14, x);
    check(32'({req1, req0, 2'b00}), x);
    ack(p);
    repeat (4) @(posedge clk);
    rd(8'h14, 32'h0);
  endtask
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {slp, ack0, ack1, wdt_en, wdt_to, t2, cmp, oth} = '0;
    void'($urandom(32'hde91));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Reset values, random write and read back of every writable register.
    for (int i = 0; i < 5; i++) begin
      rd(ra[i], 32'h0);
      v = $urandom;
      wr(ra[i], v);
      rd(ra[i], v & rm[i]);
    end
    check(32'(cmpdn), 32'(v[7]));
    wr(8'h14, 32'hff);
    rd(8'h14, 32'h0);
    rd(8'h20, 32'h0);
    check(32'(last_err), 32'h1);
    for (int i = 4; i >= 0; i--) begin
      wr(ra[i], 32'h0);
    end
    $display("test registers done");
    wr(8'h08, 32'h80);
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 4; c++) begin
        sense_run(p, 2'(c), 1'b1, 1'b1);
      end
    end
    sense_run(1, SENSE_FALL, 1'b0, 1'b0);
    wr(8'h08, 32'h0);
    sense_run(0, SENSE_FALL, 1'b1, 1'b0);
    wr(8'h08, 32'h80);
    $display("test sensing done");
    wr(8'h00, 32'h00);
    sleep_now(3'b001);
    wr(8'h00, 32'h50);
    sleep_now(3'b001);
    wr(8'h0c, 32'h80);
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h40);
    sleep_now(3'b101);
    rd(8'h14, 32'h1);
    cmp <= 1'b1;
    asleep(10);
    cmp <= 1'b0;
    exp_q.push_back(32'h1);
    oth <= 1'b1;
    wait_wake(0, 4);
    oth <= 1'b0;
    wr(8'h0c, 32'h0);
    sleep_now(3'b101);
    exp_q.push_back(32'h1);
    cmp <= 1'b1;
    wait_wake(0, 4);
    cmp <= 1'b0;
    $display("test idle done");
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h62);
    wr(8'h04, 32'h40);
    sleep_now(3'b110);
    rd(8'h14, 32'h2);
    src.low_for(0, 4);
    asleep(10);
    wdt_to <= 1'b1;
    asleep(4);
    wdt_en <= 1'b1;
    exp_q.push_back(32'h1);
    wait_wake(0, 4);
    wdt_to <= 1'b0;
    wdt_en <= 1'b0;
    ack(0);
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h60);
    wr(8'h04, 32'h40);
    sleep_now(3'b110);
    src.low_for(0, 100);
    asleep(10);
    exp_q.push_back(32'h1);
    src.drive(0, 1'b0);
    wait_wake(2000, 2100);
    rd(8'h14, 32'h4);
    src.drive(0, 1'b1);
    $display("test power down done");
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h70);
    wr(8'h10, 32'h08);
    sleep_now(3'b111);
    exp_q.push_back(32'h1);
    t2 <= 1'b1;
    wait_wake(0, 4);
    t2 <= 1'b0;
    rd(8'h00, 32'h70);
    rd(8'h10, 32'h08);
    wr(8'h10, 32'h0);
    sleep_now(3'b110);
    t2 <= 1'b1;
    asleep(10);
    t2 <= 1'b0;
    exp_q.push_back(32'h2);
    // The reset pin acts through two synchroniser stages, then wakes.
    fork
      src.reset_pulse(4);
      wait_wake(3, 6);
    join
    $display("test power save done");
    check(32'(exp_q.size()), 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
